// file: dv/fcb_builder_test.sv
`timescale 1ns/1ps
module fcb_builder_test;
	logic         i_sys_clk = 1'b0;
	logic         i_nrst = 1'b0;
	logic         i_start = 1'b0;
	logic         i_dir_sel, i_shareable, i_internal, i_total_en, i_sfn_en, slow;
	logic [2:0]   i_file_kind;
	logic [15:0]  i_file_id, i_body_len, i_obj_mem, i_struct_ovh;
	logic [15:0]  i_resv_unused, i_child_total, i_avail_mem;
	logic [7:0]   i_rec_len, i_rec_cnt, i_lcsi, o_byte, objs;
	logic [4:0]   i_app_id_len, i_prop_len, i_sec_len, i_sfn;
	logic [127:0] i_app_id, i_prop_data, i_sec_data;
	logic [1:0]   i_sec_sel;
	logic         o_valid, o_last, i_ready, o_busy, o_err;
	logic [8:0]   exp_q[$];
	logic [7:0]   bq[$];
	logic [2:0]   kinds[5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
	logic [31:0]  seed = 32'h5e688f95;
	int           mismatches = 0;
	int           comparisons = 0;
	int           nobj;

	always #10 i_sys_clk = ~i_sys_clk;

	fcb_builder #(.SZ_BYTES(2)) fcb_builder_inst (.i_sys_clk, .i_nrst, .i_start, .i_dir_sel,
		.i_shareable, .i_internal, .i_file_kind, .i_file_id, .i_rec_len, .i_rec_cnt, .i_body_len,
		.i_obj_mem, .i_struct_ovh, .i_resv_unused, .i_child_total, .i_avail_mem, .i_app_id_len,
		.i_app_id, .i_prop_len, .i_prop_data, .i_lcsi, .i_sec_sel, .i_sec_len, .i_sec_data,
		.i_total_en, .i_sfn_en, .i_sfn, .o_valid, .o_byte, .o_last, .i_ready, .o_busy, .o_err);

	fcb_term_model fcb_term_model_inst (.i_sys_clk, .i_nrst, .i_valid(o_valid), .i_byte(o_byte),
		.i_last(o_last), .i_slow(slow), .o_ready(i_ready), .o_objs(objs));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic cmp(input string what, input logic [8:0] e, input logic [8:0] s);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic put(input logic [7:0] t, input logic [4:0] n, input logic [127:0] v);
		bq.push_back(t);
		bq.push_back({3'h0, n});
		for (int i = 0; i < n; i++)
			bq.push_back(v[127-8*i -: 8]);
		nobj++;
	endtask

	// ----------------------------------------------------------------
	// expected template from the current request inputs
	// ----------------------------------------------------------------
	task automatic build();
		logic [15:0] fsz, tot;
		logic [7:0]  dsc;
		logic        rec;
		rec = !i_dir_sel && (i_file_kind == 3'h2 || i_file_kind == 3'h6);
		fsz = rec ? i_rec_len * i_rec_cnt : (i_file_kind == 3'h7 ? i_obj_mem : i_body_len);
		tot = i_dir_sel ? i_child_total + i_avail_mem
			: fsz + i_struct_ovh + (i_file_kind == 3'h7 ? i_resv_unused : 16'h0);
		dsc = i_dir_sel ? {1'b0, i_shareable, 6'h38}
			: i_file_kind == 3'h7 ? {1'b0, i_shareable, 6'h39}
			: {1'b0, i_shareable, 2'h0, i_internal, i_file_kind};
		bq = {};
		nobj = 0;
		put(8'h82, rec ? 5'h05 : 5'h02, {dsc, 8'h21, 8'h00, i_rec_len, i_rec_cnt, 88'h0});
		put(8'h83, 5'h02, {i_file_id, 112'h0});
		if (i_dir_sel && i_app_id_len != 5'h0)
			put(8'h84, i_app_id_len, i_app_id);
		if (i_prop_len != 5'h0)
			put(8'ha5, i_prop_len, i_prop_data);
		put(8'h8a, 5'h01, {i_lcsi, 120'h0});
		put(i_sec_sel == 2'h0 ? 8'h8b : i_sec_sel == 2'h1 ? 8'h8c : 8'hab, i_sec_len, i_sec_data);
		if (!i_dir_sel)
			put(8'h80, 5'h02, {fsz, 112'h0});
		if (i_total_en)
			put(8'h81, 5'h02, {tot, 112'h0});
		if (!i_dir_sel && i_sfn_en)
			put(8'h88, 5'h01, {i_sfn, 3'h0, 120'h0});
		exp_q.push_back({1'b0, 8'h62});
		exp_q.push_back({1'b0, 8'(bq.size())});
		foreach (bq[i])
			exp_q.push_back({i == bq.size() - 1, bq[i]});
	endtask

	task automatic rnd_cfg();
		i_dir_sel = xs() % 4 == 0;
		i_file_kind = i_dir_sel ? 3'h0 : kinds[xs() % 5];
		{i_shareable, i_internal, i_total_en, i_sfn_en, slow} = 5'(xs());
		{i_file_id, i_body_len} = xs();
		{i_obj_mem, i_struct_ovh} = xs();
		{i_resv_unused, i_child_total} = xs();
		{i_avail_mem, i_lcsi, i_sfn} = 29'(xs());
		i_rec_len = 8'(xs() % 255 + 1);
		i_rec_cnt = 8'(xs() % 254 + 1);
		i_app_id_len = 5'(xs() % 17);
		i_prop_len = 5'(xs() % 17);
		i_sec_sel = 2'(xs() % 3);
		i_sec_len = 5'(xs() % 16 + 1);
		i_app_id = {xs(), xs(), xs(), xs()};
		i_prop_data = {xs(), xs(), xs(), xs()};
		i_sec_data = {xs(), xs(), xs(), xs()};
	endtask

	// entered at a falling edge with the builder idle
	task automatic run(input logic bad);
		logic seen;
		seen = 1'b0;
		if (!bad)
			build();
		i_start = 1'b1;
		@(negedge i_sys_clk);
		i_start = 1'b0;
		// o_err pulses in the cycle right after the start edge
		for (int k = 0; k < 3; k++) begin
			if (o_err === 1'b1)
				seen = 1'b1;
			@(negedge i_sys_clk);
		end
		cmp("refusal", {8'h0, bad}, {8'h0, seen});
		for (int k = 0; k < 2000 && (o_busy !== 1'b0 || o_valid !== 1'b0 || exp_q.size() != 0); k++)
			@(negedge i_sys_clk);
		if (o_busy !== 1'b0 || o_valid !== 1'b0 || exp_q.size() != 0) begin
			mismatches++;
			$display("[ERR] done expected 1 seen 0");
			finish_test();
		end
		if (!bad)
			cmp("objects", {1'b0, nobj[7:0]}, {1'b0, objs});
	endtask

	always @(posedge i_sys_clk) begin
		if (i_nrst === 1'b1 && o_valid === 1'b1 && i_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				mismatches++;
				$display("[ERR] stream expected none seen %h", o_byte);
			end else
				cmp("stream", exp_q.pop_front(), {o_last, o_byte});
		end
	end

	initial begin
		rnd_cfg();
		repeat (2) @(negedge i_sys_clk);
		i_nrst = 1'b1;
		cmp("reset", 9'h0, {o_valid, o_byte});
		cmp("reset_flags", 9'h0, {7'h0, o_busy, o_err});
		for (int j = 0; j < 7; j++) begin
			rnd_cfg();
			i_dir_sel = j == 6;
			i_file_kind = kinds[j % 5];
			i_sec_sel = 2'(j % 3);
			if (j == 5) begin
				{i_file_kind, i_rec_len, i_rec_cnt} = {3'h2, 8'hff, 8'hfe};
				i_internal = 1'b1;
			end
			if (j == 6)
				{i_file_kind, i_app_id_len} = {3'h0, 5'h10};
			if (j == 3)
				{i_rec_len, i_rec_cnt} = 16'h0101;
			run(1'b0);
		end
		for (int j = 0; j < 8; j++) begin
			rnd_cfg();
			{i_dir_sel, i_file_kind} = {1'b0, 3'h2};
			case (j)
			0: i_file_kind = 3'h3;
			1: i_rec_len = 8'h00;
			2: i_rec_cnt = 8'hff;
			3: i_sec_sel = 2'h3;
			4: i_sec_len = 5'h00;
			5: i_prop_len = 5'h11;
			6: i_sec_len = 5'h11;
			default: {i_dir_sel, i_app_id_len} = {1'b1, 5'h11};
			endcase
			run(1'b1);
		end
		for (int j = 0; j < 20; j++) begin
			rnd_cfg();
			run(1'b0);
		end
		finish_test();
	end
endmodule

// file: dv/fcb_term_model.sv
`timescale 1ns/1ps
// terminal side: paces the stream and walks the object framing
module fcb_term_model (
	input  wire logic       i_sys_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_valid,
	input  wire logic [7:0] i_byte,
	input  wire logic       i_last,
	input  wire logic       i_slow,
	output logic            o_ready,
	output logic [7:0]      o_objs
);
	logic [1:0] pace_r;
	logic [2:0] st_r;
	logic [7:0] left_r;
	wire        take = i_valid & o_ready;

	// slow mode takes one byte in three, so the buffer fills and the builder must hold
	assign o_ready = !i_slow || pace_r == 2'h2;

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			pace_r <= 2'h0;
			st_r   <= 3'h0;
			left_r <= 8'h0;
			o_objs <= 8'h0;
		end else begin
			pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
			if (take) begin
				case (st_r)
				3'h0: begin
					o_objs <= 8'h0;
					st_r   <= 3'h1;
				end
				3'h1: st_r <= 3'h2;
				// any tag is counted and walked past by its length alone
				3'h2: begin
					o_objs <= o_objs + 8'h1;
					st_r   <= 3'h3;
				end
				3'h3: begin
					left_r <= i_byte;
					st_r   <= (i_byte == 8'h0) ? 3'h2 : 3'h4;
				end
				// value bytes, the data coding byte among them, are not looked at
				default: begin
					left_r <= left_r - 8'h1;
					st_r   <= (left_r == 8'h1) ? 3'h2 : 3'h4;
				end
				endcase
				if (i_last)
					st_r <= 3'h0;
			end
		end
	end
endmodule

// file: logic/fcb_builder.sv
`timescale 1ns/1ps
module fcb_builder #(
	parameter int SZ_BYTES = 2
) (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_nrst,
	input  wire logic                  i_start,
	input  wire logic                  i_dir_sel,
	input  wire logic                  i_shareable,
	input  wire logic                  i_internal,
	input  wire logic [2:0]            i_file_kind,
	input  wire logic [15:0]           i_file_id,
	input  wire logic [7:0]            i_rec_len,
	input  wire logic [7:0]            i_rec_cnt,
	input  wire logic [8*SZ_BYTES-1:0] i_body_len,
	input  wire logic [8*SZ_BYTES-1:0] i_obj_mem,
	input  wire logic [8*SZ_BYTES-1:0] i_struct_ovh,
	input  wire logic [8*SZ_BYTES-1:0] i_resv_unused,
	input  wire logic [8*SZ_BYTES-1:0] i_child_total,
	input  wire logic [8*SZ_BYTES-1:0] i_avail_mem,
	input  wire logic [4:0]            i_app_id_len,
	input  wire logic [127:0]          i_app_id,
	input  wire logic [4:0]            i_prop_len,
	input  wire logic [127:0]          i_prop_data,
	input  wire logic [7:0]            i_lcsi,
	input  wire logic [1:0]            i_sec_sel,
	input  wire logic [4:0]            i_sec_len,
	input  wire logic [127:0]          i_sec_data,
	input  wire logic                  i_total_en,
	input  wire logic                  i_sfn_en,
	input  wire logic [4:0]            i_sfn,
	output logic                       o_valid,
	output logic [7:0]                 o_byte,
	output logic                       o_last,
	input  wire logic                  i_ready,
	output logic                       o_busy,
	output logic                       o_err
);
	localparam int SZ_W = 8 * SZ_BYTES;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	fcb_pkg::fcb_state_t st_r;
	fcb_pkg::fcb_state_t st_nxt;
	fcb_pkg::fcb_obj_t   obj_r;
	fcb_pkg::fcb_obj_t   obj_nxt;
	fcb_pkg::fcb_obj_t   nxt_obj;
	logic [4:0]          bi_r;
	logic [4:0]          bi_nxt;
	logic                busy_r;
	logic                err_r;
	logic                buf_ready;
	logic [4:0]          vlen_a [0:10];
	logic [7:0]          tag_a  [0:10];
	logic [127:0]        vec_a  [0:10];
	logic [10:0]         pres;
	logic [7:0]          tpl_len;

	// ----------------------------------------------------------------
	// size computation
	// ----------------------------------------------------------------
	wire is_rec   = (i_file_kind == fcb_pkg::FK_LINEAR) || (i_file_kind == fcb_pkg::FK_CYCLIC);
	wire is_tag   = (i_file_kind == fcb_pkg::FK_TAGGED);
	wire is_trn   = (i_file_kind == fcb_pkg::FK_TRANSP);
	wire [15:0] rec_prod = 16'(i_rec_len * i_rec_cnt);
	wire [SZ_W-1:0] file_size = is_rec ? SZ_W'(rec_prod) :
		is_tag ? i_obj_mem : i_body_len;
	wire [SZ_W-1:0] total_ef = is_tag ?
		SZ_W'(file_size + i_struct_ovh + i_resv_unused) :
		SZ_W'(file_size + i_struct_ovh);
	wire [SZ_W-1:0] total_dir = SZ_W'(i_child_total + i_avail_mem);
	wire [SZ_W-1:0] total_size = i_dir_sel ? total_dir : total_ef;

	// ----------------------------------------------------------------
	// descriptor byte
	// ----------------------------------------------------------------
	wire [2:0] desc_type = (i_dir_sel || is_tag) ? fcb_pkg::DT_ALL_ONES :
		(i_internal ? fcb_pkg::DT_INTERNAL : fcb_pkg::DT_WORKING);
	wire [2:0] desc_struct = i_dir_sel ? fcb_pkg::DS_DIRECTORY :
		(is_tag ? fcb_pkg::DS_TAGGED : i_file_kind);
	wire [7:0] desc_byte = {1'b0, i_shareable, desc_type, desc_struct};
	wire rec_here = is_rec && !i_dir_sel;

	// ----------------------------------------------------------------
	// refusal of inputs that cannot be coded
	// ----------------------------------------------------------------
	wire kind_bad = !i_dir_sel && !(is_rec || is_tag || is_trn ||
		(i_file_kind == fcb_pkg::FK_NONE));
	wire rec_bad  = rec_here && ((i_rec_len == 8'h00) || (i_rec_cnt == 8'h00) ||
		(i_rec_cnt > fcb_pkg::REC_CNT_MAX));
	wire sec_bad  = (i_sec_sel > fcb_pkg::SEC_SEL_REF) || (i_sec_len == 5'h00) ||
		(i_sec_len > fcb_pkg::VAL_MAX);
	wire name_bad = i_dir_sel && (i_app_id_len > fcb_pkg::NAME_MAX);
	wire prop_bad = i_prop_len > fcb_pkg::VAL_MAX;
	wire req_bad  = kind_bad || rec_bad || sec_bad || name_bad || prop_bad;
	wire accept   = (st_r == fcb_pkg::ST_IDLE) && i_start && !req_bad;
	wire refuse   = (st_r == fcb_pkg::ST_IDLE) && i_start && req_bad;

	// ----------------------------------------------------------------
	// object table
	// ----------------------------------------------------------------
	assign pres[fcb_pkg::OB_WRAP]  = 1'b1;
	assign pres[fcb_pkg::OB_DESC]  = 1'b1;
	assign pres[fcb_pkg::OB_FID]   = 1'b1;
	assign pres[fcb_pkg::OB_NAME]  = i_dir_sel && (i_app_id_len != 5'h00);
	assign pres[fcb_pkg::OB_PROP]  = i_prop_len != 5'h00;
	assign pres[fcb_pkg::OB_LCSI]  = 1'b1;
	assign pres[fcb_pkg::OB_SEC]   = 1'b1;
	assign pres[fcb_pkg::OB_SIZE]  = !i_dir_sel;
	assign pres[fcb_pkg::OB_TOTAL] = i_total_en;
	assign pres[fcb_pkg::OB_SFN]   = !i_dir_sel && i_sfn_en;
	assign pres[fcb_pkg::OB_END]   = 1'b0;

	assign vlen_a[0]  = 5'h00;
	assign vlen_a[1]  = rec_here ? fcb_pkg::DESC_LEN_REC : fcb_pkg::DESC_LEN_SHORT;
	assign vlen_a[2]  = fcb_pkg::FID_LEN;
	assign vlen_a[3]  = i_app_id_len;
	assign vlen_a[4]  = i_prop_len;
	assign vlen_a[5]  = fcb_pkg::ONE_LEN;
	assign vlen_a[6]  = i_sec_len;
	assign vlen_a[7]  = 5'(SZ_BYTES);
	assign vlen_a[8]  = 5'(SZ_BYTES);
	assign vlen_a[9]  = fcb_pkg::ONE_LEN;
	assign vlen_a[10] = 5'h00;

	wire [7:0] sec_tag = (i_sec_sel == fcb_pkg::SEC_SEL_EXP) ? fcb_pkg::TAG_SEC_EXP :
		(i_sec_sel == fcb_pkg::SEC_SEL_COMPACT) ? fcb_pkg::TAG_SEC_COMPACT :
		fcb_pkg::TAG_SEC_REF;
	assign tag_a[0]  = fcb_pkg::TAG_TEMPLATE;
	assign tag_a[1]  = fcb_pkg::TAG_DESC;
	assign tag_a[2]  = fcb_pkg::TAG_FID;
	assign tag_a[3]  = fcb_pkg::TAG_NAME;
	assign tag_a[4]  = fcb_pkg::TAG_PROP;
	assign tag_a[5]  = fcb_pkg::TAG_LCSI;
	assign tag_a[6]  = sec_tag;
	assign tag_a[7]  = fcb_pkg::TAG_SIZE;
	assign tag_a[8]  = fcb_pkg::TAG_TOTAL;
	assign tag_a[9]  = fcb_pkg::TAG_SFN;
	assign tag_a[10] = 8'h00;

	// values packed most significant byte first
	assign vec_a[0]  = 128'h0;
	assign vec_a[1]  = {desc_byte, fcb_pkg::DATA_CODING, 8'h00, i_rec_len, i_rec_cnt,
		88'h0};
	assign vec_a[2]  = {i_file_id, 112'h0};
	assign vec_a[3]  = i_app_id;
	assign vec_a[4]  = i_prop_data;
	assign vec_a[5]  = {i_lcsi, 120'h0};
	assign vec_a[6]  = i_sec_data;
	assign vec_a[7]  = {file_size, {(128 - SZ_W){1'b0}}};
	assign vec_a[8]  = {total_size, {(128 - SZ_W){1'b0}}};
	assign vec_a[9]  = {i_sfn, 3'h0, 120'h0};
	assign vec_a[10] = 128'h0;

	always_comb begin
		tpl_len = 8'h00;
		for (int k = 1; k < 10; k++) begin
			if (pres[k]) begin
				tpl_len = tpl_len + 8'(vlen_a[k]) + 8'h02;
			end
		end
	end

	always_comb begin
		nxt_obj = fcb_pkg::OB_END;
		for (int k = 10; k >= 1; k--) begin
			if ((4'(k) > obj_r) && pres[k]) begin
				nxt_obj = fcb_pkg::fcb_obj_t'(4'(k));
			end
		end
	end

	// ----------------------------------------------------------------
	// byte selection and stepping
	// ----------------------------------------------------------------
	wire [4:0]   cur_vlen = vlen_a[obj_r];
	wire [127:0] vshift   = vec_a[obj_r] << {bi_r - 5'h02, 3'h0};
	wire [7:0]   len_byte = (obj_r == fcb_pkg::OB_WRAP) ? tpl_len : 8'(cur_vlen);
	wire [7:0]   cur_byte = (bi_r == 5'h00) ? tag_a[obj_r] :
		(bi_r == 5'h01) ? len_byte : vshift[127:120];
	wire         obj_last = bi_r == 5'(cur_vlen + 5'h01);
	wire         run      = st_r == fcb_pkg::ST_RUN;
	wire         push     = run && buf_ready;
	wire         end_byte = obj_last && (nxt_obj == fcb_pkg::OB_END);

	always_comb begin
		st_nxt  = st_r;
		obj_nxt = obj_r;
		bi_nxt  = bi_r;
		case (st_r)
			fcb_pkg::ST_IDLE: begin
				if (accept) begin
					st_nxt  = fcb_pkg::ST_RUN;
					obj_nxt = fcb_pkg::OB_WRAP;
					bi_nxt  = 5'h00;
				end
			end
			fcb_pkg::ST_RUN: begin
				if (push && obj_last) begin
					obj_nxt = nxt_obj;
					bi_nxt  = 5'h00;
					if (end_byte) begin
						st_nxt = fcb_pkg::ST_IDLE;
					end
				end else if (push) begin
					bi_nxt = bi_r + 5'h01;
				end
			end
			default: begin
				st_nxt = fcb_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			st_r   <= fcb_pkg::ST_IDLE;
			obj_r  <= fcb_pkg::OB_WRAP;
			bi_r   <= 5'h00;
			busy_r <= 1'b0;
			err_r  <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			obj_r  <= obj_nxt;
			bi_r   <= bi_nxt;
			busy_r <= st_nxt == fcb_pkg::ST_RUN;
			err_r  <= refuse;
		end
	end

	assign o_busy = busy_r;
	assign o_err  = err_r;

	fcb_pair_buf #(
		.W (9)
	) u_buf (
		.i_sys_clk   (i_sys_clk),
		.i_nrst      (i_nrst),
		.i_in_valid  (run),
		.i_in_data   ({end_byte, cur_byte}),
		.o_in_ready  (buf_ready),
		.o_out_valid (o_valid),
		.o_out_data  ({o_last, o_byte}),
		.i_out_ready (i_ready)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	chk_order_rise: assert property (run && $past(st_r) == fcb_pkg::ST_RUN |->
		obj_r >= $past(obj_r)) else $error("objects out of order");
	chk_mand_head: assert property (push && obj_last && obj_r == fcb_pkg::OB_WRAP |=>
		obj_r == fcb_pkg::OB_DESC) else $error("descriptor not first");
	chk_mand_objs: assert property (push && obj_last && obj_r == fcb_pkg::OB_SEC |=>
		i_dir_sel || obj_r == fcb_pkg::OB_SIZE) else $error("mandatory object missing");
	chk_sec_tag: assert property (push && obj_r == fcb_pkg::OB_SEC && bi_r == 5'h00 |->
		cur_byte inside {8'h8b, 8'h8c, 8'hab}) else $error("bad security tag");
	chk_size_len: assert property (push && obj_r == fcb_pkg::OB_SIZE && bi_r == 5'h01 |->
		cur_byte >= 8'h02 && !i_dir_sel) else $error("bad size length");
	chk_size_rec: assert property (run && is_rec |->
		file_size == SZ_W'(i_rec_len * i_rec_cnt)) else $error("bad record file size");
	chk_total_len: assert property (push && obj_r == fcb_pkg::OB_TOTAL && bi_r == 5'h00
		##1 push [*1] |-> cur_byte >= 8'h02) else $error("bad total length");
	chk_total_tag: assert property (run && is_tag && !i_dir_sel |->
		total_size == SZ_W'(i_obj_mem + i_struct_ovh + i_resv_unused))
		else $error("bad tagged total");
	chk_total_dir: assert property (run && i_dir_sel |->
		total_size == SZ_W'(i_child_total + i_avail_mem)) else $error("bad directory total");
	chk_desc_len: assert property (push && obj_r == fcb_pkg::OB_DESC && bi_r == 5'h01 |->
		cur_byte == (rec_here ? 8'h05 : 8'h02)) else $error("bad descriptor length");
	chk_desc_code: assert property (push && obj_r == fcb_pkg::OB_DESC && bi_r == 5'h03 |->
		cur_byte == 8'h21) else $error("bad data coding byte");
	chk_rec_range: assert property (push && obj_r == fcb_pkg::OB_DESC && bi_r == 5'h06 |->
		cur_byte != 8'h00 && cur_byte != 8'hff) else $error("record count out of range");
	chk_rec_len: assert property (push && obj_r == fcb_pkg::OB_DESC && bi_r == 5'h05 |->
		cur_byte != 8'h00) else $error("record length zero");
	chk_rec_high: assert property (push && obj_r == fcb_pkg::OB_DESC && bi_r == 5'h04 |->
		cur_byte == 8'h00) else $error("record length high byte not zero");
	chk_desc_top: assert property (push && obj_r == fcb_pkg::OB_DESC && bi_r == 5'h02 |->
		!cur_byte[7] && cur_byte[6] == i_shareable) else $error("bad descriptor top bits");
	chk_name_len: assert property (push && obj_r == fcb_pkg::OB_NAME && bi_r == 5'h01 |->
		cur_byte inside {[8'h01:8'h10]}) else $error("bad name length");
	chk_fid_walk: assert property (push && obj_r == fcb_pkg::OB_FID && bi_r == 5'h00 |=>
		obj_r == fcb_pkg::OB_FID && bi_r == 5'h01) else $error("identifier walk broken");
	chk_step_one: assert property (push && !obj_last |=> bi_r == $past(bi_r) + 5'h01)
		else $error("byte index skipped");

	cov_rec_file: cover property (accept && rec_here);
	cov_dir_name: cover property (push && obj_r == fcb_pkg::OB_NAME);
	cov_stall: cover property (run && !buf_ready);
	cov_refuse: cover property (refuse);
endmodule

// file: logic/fcb_pair_buf.sv
`timescale 1ns/1ps
// two-entry buffer; output side registered
module fcb_pair_buf #(
	parameter int W = 9
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_nrst,
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	output logic              o_out_valid,
	output logic      [W-1:0] o_out_data,
	input  wire logic         i_out_ready
);
	logic         v0_r;
	logic         v1_r;
	logic [W-1:0] d0_r;
	logic [W-1:0] d1_r;
	logic         v0_nxt;
	logic         v1_nxt;
	logic [W-1:0] d0_nxt;
	logic [W-1:0] d1_nxt;
	wire          pop  = v0_r & i_out_ready;
	wire          push = i_in_valid & ~v1_r;

	assign o_in_ready  = ~v1_r;
	assign o_out_valid = v0_r;
	assign o_out_data  = d0_r;

	always_comb begin
		v0_nxt = v0_r;
		v1_nxt = v1_r;
		d0_nxt = d0_r;
		d1_nxt = d1_r;
		if (pop) begin
			d0_nxt = v1_r ? d1_r : i_in_data;
			v0_nxt = v1_r | push;
			if (v1_r && push) begin
				d1_nxt = i_in_data;
			end else begin
				v1_nxt = 1'b0;
			end
		end else if (push) begin
			if (!v0_r) begin
				d0_nxt = i_in_data;
				v0_nxt = 1'b1;
			end else begin
				d1_nxt = i_in_data;
				v1_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			v0_r <= 1'b0;
			v1_r <= 1'b0;
			d0_r <= '0;
			d1_r <= '0;
		end else begin
			v0_r <= v0_nxt;
			v1_r <= v1_nxt;
			d0_r <= d0_nxt;
			d1_r <= d1_nxt;
		end
	end
endmodule

// file: logic/fcb_pkg.sv
package fcb_pkg;

	// ----------------------------------------------------------------
	// object tags
	// ----------------------------------------------------------------
	localparam logic [7:0] TAG_TEMPLATE    = 8'h62;
	localparam logic [7:0] TAG_DESC        = 8'h82;
	localparam logic [7:0] TAG_FID         = 8'h83;
	localparam logic [7:0] TAG_NAME        = 8'h84;
	localparam logic [7:0] TAG_PROP        = 8'ha5;
	localparam logic [7:0] TAG_LCSI        = 8'h8a;
	localparam logic [7:0] TAG_SEC_EXP     = 8'h8b;
	localparam logic [7:0] TAG_SEC_COMPACT = 8'h8c;
	localparam logic [7:0] TAG_SEC_REF     = 8'hab;
	localparam logic [7:0] TAG_SIZE        = 8'h80;
	localparam logic [7:0] TAG_TOTAL       = 8'h81;
	localparam logic [7:0] TAG_SFN         = 8'h88;

	// ----------------------------------------------------------------
	// fixed lengths and values
	// ----------------------------------------------------------------
	localparam logic [4:0] DESC_LEN_SHORT  = 5'h02;
	localparam logic [4:0] DESC_LEN_REC    = 5'h05;
	localparam logic [7:0] DATA_CODING     = 8'h21;
	localparam logic [4:0] FID_LEN         = 5'h02;
	localparam logic [4:0] ONE_LEN         = 5'h01;
	localparam logic [4:0] NAME_MAX        = 5'h10;
	localparam logic [4:0] VAL_MAX         = 5'h10;
	localparam logic [7:0] REC_CNT_MAX     = 8'hfe;
	localparam int         SFN_POS         = 3;

	// ----------------------------------------------------------------
	// descriptor byte fields and file kinds
	// ----------------------------------------------------------------
	localparam int         DESC_SHARE_BIT  = 6;
	localparam logic [2:0] DT_WORKING      = 3'h0;
	localparam logic [2:0] DT_INTERNAL     = 3'h1;
	localparam logic [2:0] DT_ALL_ONES     = 3'h7;
	localparam logic [2:0] DS_DIRECTORY    = 3'h0;
	localparam logic [2:0] DS_TAGGED       = 3'h1;
	localparam logic [2:0] FK_NONE         = 3'h0;
	localparam logic [2:0] FK_TRANSP       = 3'h1;
	localparam logic [2:0] FK_LINEAR       = 3'h2;
	localparam logic [2:0] FK_CYCLIC       = 3'h6;
	localparam logic [2:0] FK_TAGGED       = 3'h7;
	localparam logic [1:0] SEC_SEL_EXP     = 2'h0;
	localparam logic [1:0] SEC_SEL_COMPACT = 2'h1;
	localparam logic [1:0] SEC_SEL_REF     = 2'h2;

	typedef enum logic [3:0] {
		OB_WRAP  = 4'h0,
		OB_DESC  = 4'h1,
		OB_FID   = 4'h2,
		OB_NAME  = 4'h3,
		OB_PROP  = 4'h4,
		OB_LCSI  = 4'h5,
		OB_SEC   = 4'h6,
		OB_SIZE  = 4'h7,
		OB_TOTAL = 4'h8,
		OB_SFN   = 4'h9,
		OB_END   = 4'ha
	} fcb_obj_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} fcb_state_t;

endpackage
